// >>> core/sdc_crc8_word.v
// crc-8 folding of one register word, msb first
`timescale 1ns/1ns
`default_nettype none
`include "sdc_seq_regs.vh"

module sdc_crc8_word #(
  parameter W = 24
) (
  // running value in, word, updated value out
  input wire [7:0] crc_in,
  input wire [W-1:0] word,
  output reg [7:0] crc_out
);

  integer i;

  always @* begin
    crc_out = crc_in;
    for (i = W - 1; i >= 0; i = i - 1) begin
      if (crc_out[7] ^ word[i]) begin
        crc_out = {crc_out[6:0], 1'b0} ^ `SDC_CRC_POLY;
      end else begin
        crc_out = {crc_out[6:0], 1'b0};
      end
    end
  end

endmodule // sdc_crc8_word
`default_nettype wire

// >>> core/sdc_seq_core.v
// channel sequencer, clock tally and map integrity checks
`timescale 1ns/1ns
`default_nettype none
`include "sdc_seq_regs.vh"

module sdc_seq_core #(
  parameter MAP_CHECK_CYC = `SDC_MAP_CHECK_CYC
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // register write port from the serial front end
  input wire reg_wr,
  input wire [7:0] reg_wr_addr,
  input wire [23:0] reg_wr_data,
  input wire reg_wr_sum_bad,
  // register read port
  input wire reg_rd,
  input wire [7:0] reg_rd_addr,
  output reg [23:0] reg_rd_data,
  output reg reg_rd_valid,
  // main clock pin
  input wire mclk_pin,
  // other writers of the map
  input wire cal_update,
  input wire single_seq_idle,
  input wire streaming_readout_off,
  // rom check engine
  output reg rom_check_start,
  input wire rom_check_done,
  input wire rom_check_bad,
  // converter
  input wire conv_done,
  output wire conv_run,
  output wire [3:0] conv_slot,
  output wire [2:0] conv_setup,
  output reg [3:0] status_slot_tag,
  // fault flags
  input wire [2:0] fault_clr,
  output reg serial_sum_fault,
  output reg map_integrity_fault,
  output reg rom_fault
);

  localparam MW_IDLE = 1'b0;
  localparam MW_WALK = 1'b1;

  // register storage
  reg [23:0] slot_cfg [0:15];
  reg [23:0] mask_reg;
  reg [7:0] osc_tick_tally;
  reg [7:0] tally_pre;

  // main clock synchroniser and edge
  reg mclk_s1;
  reg mclk_s2;
  reg mclk_s3;
  reg mclk_lvl;
  wire mclk_rise;

  // sequencer
  reg [3:0] seq_cur;
  wire [15:0] slot_on;
  wire seq_any;
  wire [3:0] seq_pick;

  // map walk
  reg mw_state;
  reg mw_ref;
  reg [4:0] mw_idx;
  reg [7:0] mw_crc;
  reg [7:0] map_ref;
  reg map_dirty;
  reg check_due;
  reg [15:0] period_cnt;
  wire [7:0] mw_crc_next;
  reg [23:0] mw_word;

  // misc
  reg rom_started;
  wire wr_ok;
  wire wr_slot;
  wire [3:0] wr_slot_idx;
  wire map_write;
  wire map_check_on;
  wire sum_check_on;
  wire rom_rep_on;
  wire osc_tick_tally_on;
  wire [7:0] slot_off;
  wire [7:0] rd_off;
  integer i;

  assign map_check_on = mask_reg[`SDC_MASK_MAP_BIT];
  assign sum_check_on = mask_reg[`SDC_MASK_SUM_BIT];
  assign rom_rep_on = mask_reg[`SDC_MASK_ROM_BIT];
  assign osc_tick_tally_on = mask_reg[`SDC_MASK_TALLY_BIT];

  // a write with a bad checksum is dropped while checking is on
  assign wr_ok = reg_wr && !(sum_check_on && reg_wr_sum_bad);
  assign slot_off = reg_wr_addr - `SDC_ADDR_SLOT0;
  assign wr_slot_idx = slot_off[3:0];
  assign wr_slot = (reg_wr_addr >= `SDC_ADDR_SLOT0) && (reg_wr_addr <= `SDC_ADDR_SLOT15);
  assign map_write = (wr_ok && (wr_slot || reg_wr_addr == `SDC_ADDR_MASK))
    || cal_update || single_seq_idle || streaming_readout_off;

  // slot registers and mask register
  always @(posedge clk) begin
    if (srst) begin
      slot_cfg[0] <= `SDC_SLOT0_RST;
      for (i = 1; i < 16; i = i + 1) begin
        slot_cfg[i] <= `SDC_SLOTM_RST;
      end
      mask_reg <= `SDC_MASK_RST;
    end else if (wr_ok) begin
      if (reg_wr_addr == `SDC_ADDR_MASK) begin
        mask_reg <= reg_wr_data & `SDC_MASK_WMASK;
      end else if (wr_slot) begin
        if (wr_slot_idx == 4'h0) begin
          slot_cfg[0] <= reg_wr_data & `SDC_SLOT0_WMASK;
        end else begin
          slot_cfg[wr_slot_idx] <= reg_wr_data & `SDC_SLOTM_WMASK;
        end
      end
    end
  end

  // register reads, answered one cycle later
  assign rd_off = reg_rd_addr - `SDC_ADDR_SLOT0;
  always @(posedge clk) begin
    if (srst) begin
      reg_rd_data <= 24'h000000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (!reg_rd) begin
        reg_rd_data <= reg_rd_data;
      end else if (reg_rd_addr == `SDC_ADDR_MASK) begin
        reg_rd_data <= mask_reg;
      end else if (reg_rd_addr == `SDC_ADDR_TALLY) begin
        reg_rd_data <= {16'h0000, osc_tick_tally_on ? osc_tick_tally : 8'h00};
      end else if (reg_rd_addr >= `SDC_ADDR_SLOT0 && reg_rd_addr <= `SDC_ADDR_SLOT15) begin
        reg_rd_data <= slot_cfg[rd_off[3:0]];
      end else begin
        reg_rd_data <= 24'h000000;
      end
    end
  end

  // main clock pin: three flops, edge once second and third agree
  assign mclk_rise = (mclk_s2 == mclk_s3) && mclk_s3 && !mclk_lvl;
  always @(posedge clk) begin
    if (srst) begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
      mclk_lvl <= 1'b0;
    end else begin
      mclk_s1 <= mclk_pin;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
      if (mclk_s2 == mclk_s3) begin
        mclk_lvl <= mclk_s3;
      end
    end
  end

  // clock tally
  always @(posedge clk) begin
    if (srst) begin
      osc_tick_tally <= `SDC_TALLY_RST;
      tally_pre <= 8'h00;
    end else if (osc_tick_tally_on && mclk_rise) begin
      if (tally_pre == `SDC_TALLY_DIV - 8'd1) begin
        tally_pre <= 8'h00;
        osc_tick_tally <= osc_tick_tally + 8'd1;
      end else begin
        tally_pre <= tally_pre + 8'd1;
      end
    end
  end

  // sequencer
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_on
      assign slot_on[g] = slot_cfg[g][`SDC_SLOT_EN_BIT];
    end
  endgenerate

  sdc_slot_pick #(
    .N(16),
    .SW(4)
  ) u_pick (
    .slot_on(slot_on),
    .start(seq_cur),
    .any_on(seq_any),
    .pick(seq_pick)
  );

  assign conv_run = seq_any;
  assign conv_slot = seq_pick;
  // shared setup values are legal; the selector is a plain field
  assign conv_setup = slot_cfg[seq_pick][`SDC_SLOT_SETUP_HI:`SDC_SLOT_SETUP_LO];

  always @(posedge clk) begin
    if (srst) begin
      seq_cur <= 4'h0;
      status_slot_tag <= 4'h0;
    end else if (conv_done && seq_any) begin
      status_slot_tag <= seq_pick;
      seq_cur <= seq_pick + 4'h1;
    end
  end

  // map checksum walk over writable words only
  always @* begin
    if (mw_idx < 5'd16) begin
      mw_word = slot_cfg[mw_idx[3:0]];
    end else begin
      mw_word = mask_reg;
    end
  end

  sdc_crc8_word #(
    .W(24)
  ) u_crc (
    .crc_in(mw_crc),
    .word(mw_word),
    .crc_out(mw_crc_next)
  );

  // periodic check tick
  always @(posedge clk) begin
    if (srst) begin
      period_cnt <= 16'h0000;
    end else if (period_cnt == MAP_CHECK_CYC[15:0] - 16'h0001) begin
      period_cnt <= 16'h0000;
    end else begin
      period_cnt <= period_cnt + 16'h0001;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      mw_state <= MW_IDLE;
      mw_ref <= 1'b0;
      mw_idx <= 5'd0;
      mw_crc <= `SDC_CRC_SEED;
      map_ref <= 8'h00;
      map_dirty <= 1'b1;
      check_due <= 1'b0;
    end else begin
      if (period_cnt == MAP_CHECK_CYC[15:0] - 16'h0001) begin
        check_due <= 1'b1;
      end
      case (mw_state)
        MW_IDLE: begin
          mw_idx <= 5'd0;
          mw_crc <= `SDC_CRC_SEED;
          if (map_write) begin
            map_dirty <= 1'b1;
          end else if (map_dirty) begin
            mw_state <= MW_WALK;
            mw_ref <= 1'b1;
            map_dirty <= 1'b0;
          end else if (check_due) begin
            mw_state <= MW_WALK;
            mw_ref <= 1'b0;
            check_due <= 1'b0;
          end
        end
        MW_WALK: begin
          if (map_write) begin
            // contents moved under the walk; start over as a reference walk
            mw_state <= MW_IDLE;
            map_dirty <= 1'b1;
          end else if (mw_idx == `SDC_MAP_WORDS - 5'd1) begin
            mw_state <= MW_IDLE;
            if (mw_ref) begin
              map_ref <= mw_crc_next;
            end
          end else begin
            mw_idx <= mw_idx + 5'd1;
            mw_crc <= mw_crc_next;
          end
        end
        default: begin
          mw_state <= MW_IDLE;
        end
      endcase
    end
  end

  // rom check kick after reset release
  always @(posedge clk) begin
    if (srst) begin
      rom_started <= 1'b0;
      rom_check_start <= 1'b0;
    end else begin
      rom_started <= 1'b1;
      rom_check_start <= !rom_started;
    end
  end

  // sticky faults; a set in the clearing cycle wins
  always @(posedge clk) begin
    if (srst) begin
      serial_sum_fault <= 1'b0;
      map_integrity_fault <= 1'b0;
      rom_fault <= 1'b0;
    end else begin
      if (reg_wr && reg_wr_sum_bad && sum_check_on) begin
        serial_sum_fault <= 1'b1;
      end else if (fault_clr[`SDC_FLT_SUM]) begin
        serial_sum_fault <= 1'b0;
      end
      if (mw_state == MW_WALK && !mw_ref && !map_write && mw_idx == `SDC_MAP_WORDS - 5'd1
          && mw_crc_next != map_ref && map_check_on) begin
        map_integrity_fault <= 1'b1;
      end else if (fault_clr[`SDC_FLT_MAP]) begin
        map_integrity_fault <= 1'b0;
      end
      if (rom_check_done && rom_check_bad && rom_rep_on) begin
        rom_fault <= 1'b1;
      end else if (fault_clr[`SDC_FLT_ROM]) begin
        rom_fault <= 1'b0;
      end
    end
  end

endmodule // sdc_seq_core
`default_nettype wire

// >>> core/sdc_seq_regs.vh
// register map, field positions, reset values and timing counts
`ifndef SDC_SEQ_REGS_VH
`define SDC_SEQ_REGS_VH

// register addresses
`define SDC_ADDR_MASK 8'h07
`define SDC_ADDR_TALLY 8'h08
`define SDC_ADDR_SLOT0 8'h09
`define SDC_ADDR_SLOT15 8'h18

// fault_report_mask fields
`define SDC_MASK_ROM_BIT 0
`define SDC_MASK_MAP_BIT 1
`define SDC_MASK_SUM_BIT 2
`define SDC_MASK_TALLY_BIT 22
`define SDC_MASK_RST 24'h000000
`define SDC_MASK_WMASK 24'h400007

// channel slot fields
`define SDC_SLOT_EN_BIT 23
`define SDC_SLOT_SETUP_HI 22
`define SDC_SLOT_SETUP_LO 20
`define SDC_SLOT0_RST 24'h800100
`define SDC_SLOTM_RST 24'h000100
`define SDC_SLOT0_WMASK 24'hFBFFFF
`define SDC_SLOTM_WMASK 24'hF3FFFF

// clock tally
`define SDC_TALLY_RST 8'h00
`define SDC_TALLY_DIV 8'd131

// fault clear lanes
`define SDC_FLT_SUM 0
`define SDC_FLT_MAP 1
`define SDC_FLT_ROM 2

// timing: system clock period and map check period, both in ns
`define SDC_CLK_PERIOD_NS 50
`define SDC_MAP_CHECK_NS 426600
`define SDC_MAP_CHECK_CYC (`SDC_MAP_CHECK_NS / `SDC_CLK_PERIOD_NS)

// map checksum
`define SDC_CRC_POLY 8'h07
`define SDC_CRC_SEED 8'hFF
`define SDC_MAP_WORDS 5'd17

`endif

// >>> core/sdc_slot_pick.v
// first enabled slot at or after a start slot, wrapping upward
`timescale 1ns/1ns
`default_nettype none

module sdc_slot_pick #(
  parameter N = 16,
  parameter SW = 4
) (
  // enables and start point
  input wire [N-1:0] slot_on,
  input wire [SW-1:0] start,
  // result
  output reg any_on,
  output reg [SW-1:0] pick
);

  integer k;
  reg [SW-1:0] idx;

  always @* begin
    any_on = |slot_on;
    pick = start;
    idx = start;
    // descending scan so the nearest slot upward wins
    for (k = N - 1; k >= 0; k = k - 1) begin
      idx = start + k[SW-1:0];
      if (slot_on[idx]) begin
        pick = idx;
      end
    end
  end

endmodule // sdc_slot_pick
`default_nettype wire

// >>> tb/sdc_host_model.sv
// host side register access model
`timescale 1ns/1ns
`default_nettype none
module sdc_host_model (
  // clock
  input wire logic clk,
  // write port
  output logic reg_wr,
  output logic [7:0] reg_wr_addr,
  output logic [23:0] reg_wr_data,
  output logic reg_wr_sum_bad,
  // read port
  output logic reg_rd,
  output logic [7:0] reg_rd_addr,
  input wire logic [23:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  initial begin
    reg_wr = 1'b0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 24'h000000;
    reg_wr_sum_bad = 1'b0;
    reg_rd = 1'b0;
    reg_rd_addr = 8'h00;
  end
  // released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [23:0] d, input logic bad);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_wr_addr <= a;
    reg_wr_data <= d;
    reg_wr_sum_bad <= bad;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wr_addr <= ~a;
    reg_wr_data <= ~d;
    reg_wr_sum_bad <= ~bad;
  endtask
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    int n;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_rd_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_rd_addr <= ~a;
    n = 0;
    d = 24'hXXXXXX;
    do begin
      @(posedge clk);
      n++;
    end while (reg_rd_valid !== 1'b1 && n < 4);
    if (reg_rd_valid === 1'b1) d = reg_rd_data;
  endtask
endmodule // sdc_host_model
`default_nettype wire

// >>> tb/sdc_seq_checker.sv
// port assertions for the sequencer core
`timescale 1ns/1ns
`default_nettype none
module sdc_seq_checker #(
  parameter MAP_CHECK_CYC = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register ports
  input wire logic reg_wr,
  input wire logic reg_wr_sum_bad,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [23:0] reg_rd_data,
  input wire logic reg_rd_valid,
  // rom, converter, faults
  input wire logic rom_check_start,
  input wire logic rom_check_done,
  input wire logic conv_done,
  input wire logic conv_run,
  input wire logic [3:0] conv_slot,
  input wire logic [3:0] status_slot_tag,
  input wire logic [2:0] fault_clr,
  input wire logic serial_sum_fault,
  input wire logic rom_fault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  AST_RD_VALID: assert property (reg_rd |=> reg_rd_valid)
    else $error("read not answered");
  AST_VALID_CAUSE: assert property (reg_rd_valid |-> $past(reg_rd))
    else $error("valid without read");
  AST_UNMAPPED: assert property (reg_rd && reg_rd_addr > 8'h18 |=> reg_rd_data == 24'h000000)
    else $error("unmapped read not zero");
  AST_TAG: assert property (conv_done && conv_run |=> status_slot_tag == $past(conv_slot))
    else $error("tag not slot");
  AST_IDLE_TAG: assert property (conv_done && !conv_run |=> $stable(status_slot_tag))
    else $error("tag moved when idle");
  AST_ROM_START: assert property ($fell(srst) |-> ##[0:2] rom_check_start)
    else $error("no rom check");
  AST_ROM_PULSE: assert property (rom_check_start |=> !rom_check_start)
    else $error("rom start too long");
  AST_SUM_SET: assert property (!serial_sum_fault && !(reg_wr && reg_wr_sum_bad) |=> !serial_sum_fault)
    else $error("sum fault without cause");
  AST_SUM_HOLD: assert property (serial_sum_fault && !fault_clr[0] |=> serial_sum_fault)
    else $error("sum fault lost");
  AST_ROM_CLR: assert property (rom_fault && fault_clr[2] && !rom_check_done |=> !rom_fault)
    else $error("rom fault not cleared");
  AST_ROM_SET: assert property (!rom_fault && !rom_check_done |=> !rom_fault)
    else $error("rom fault without cause");
endmodule // sdc_seq_checker
bind sdc_seq_core sdc_seq_checker #(.MAP_CHECK_CYC(MAP_CHECK_CYC)) sdc_seq_checker_inst (.clk(clk), .srst(srst),
  .reg_wr(reg_wr), .reg_wr_sum_bad(reg_wr_sum_bad), .reg_rd(reg_rd), .reg_rd_addr(reg_rd_addr),
  .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .rom_check_start(rom_check_start),
  .rom_check_done(rom_check_done), .conv_done(conv_done), .conv_run(conv_run), .conv_slot(conv_slot),
  .status_slot_tag(status_slot_tag), .fault_clr(fault_clr), .serial_sum_fault(serial_sum_fault),
  .rom_fault(rom_fault));
`default_nettype wire

// >>> tb/tb_channel_sequencer_and_integrity_checks.sv
// self-checking bench for the sequencer core
`timescale 1ns/1ns
`default_nettype none
module tb_channel_sequencer_and_integrity_checks;
  logic clk = 1'b0;
  logic srst, mclk_pin, mclk_run, conv_done, rom_kick, rom_check_done, rom_seen, rom_bad;
  logic [2:0] oth, fault_clr, mcnt;
  logic reg_wr, reg_wr_sum_bad, reg_rd, reg_rd_valid, rom_check_start, conv_run;
  logic serial_sum_fault, map_integrity_fault, rom_fault;
  logic [7:0] reg_wr_addr, reg_rd_addr;
  logic [23:0] reg_wr_data, reg_rd_data;
  logic [3:0] conv_slot, status_slot_tag;
  logic [2:0] conv_setup;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  sdc_seq_core #(.MAP_CHECK_CYC(200)) sdc_seq_core_inst (.clk(clk), .srst(srst), .reg_wr(reg_wr),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_wr_sum_bad(reg_wr_sum_bad), .reg_rd(reg_rd),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .mclk_pin(mclk_pin),
    .cal_update(oth[0]), .single_seq_idle(oth[1]), .streaming_readout_off(oth[2]),
    .rom_check_start(rom_check_start), .rom_check_done(rom_check_done), .rom_check_bad(rom_bad),
    .conv_done(conv_done), .conv_run(conv_run), .conv_slot(conv_slot), .conv_setup(conv_setup),
    .status_slot_tag(status_slot_tag), .fault_clr(fault_clr), .serial_sum_fault(serial_sum_fault),
    .map_integrity_fault(map_integrity_fault), .rom_fault(rom_fault));
  sdc_host_model sdc_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_sum_bad(reg_wr_sum_bad), .reg_rd(reg_rd), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));
  // rom engine answers each start, main clock of 8 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rom_check_done <= rom_check_start | rom_kick;
    if (rom_check_start) rom_seen <= 1'b1;
    mcnt <= mcnt + 3'h1;
    if (mclk_run) mclk_pin <= mcnt[2];
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [23:0] e);
    logic [23:0] d;
    sdc_host_model_inst.rd(a, d);
    chk("register", d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d, input logic bad);
    sdc_host_model_inst.wr(a, d, bad);
  endtask
  task automatic pulse_done();
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
  endtask
  task automatic clr(input logic [2:0] b);
    @(posedge clk);
    fault_clr <= b;
    @(posedge clk);
    fault_clr <= 3'h0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 16; i++) rchk(8'h09 + i[7:0], i == 0 ? 24'h800100 : 24'h000100);
    rchk(8'h07, 24'h000000);
    rchk(8'h08, 24'h000000);
    rchk(8'h19, 24'h000000);
    chk("rom_seen", {23'h0, rom_seen}, 24'h000001);
    chk("rom_fault", {23'h0, rom_fault}, 24'h000000);
    chk("conv_slot", {20'h0, conv_slot}, 24'h000000);
  endtask
  task automatic t_sum();
    wr(8'h07, 24'h000004, 1'b0);
    wr(8'h0A, 24'h123456, 1'b1);
    rchk(8'h0A, 24'h000100);
    chk("sum_fault", {23'h0, serial_sum_fault}, 24'h000001);
    clr(3'h1);
    wr(8'h07, 24'h000000, 1'b0);
    wr(8'h0A, 24'h123456, 1'b1);
    rchk(8'h0A, 24'h123456);
    chk("sum_fault", {23'h0, serial_sum_fault}, 24'h000000);
  endtask
  task automatic t_rom();
    wr(8'h07, 24'h000001, 1'b0);
    // a passing check first, then a failing one
    for (int b = 0; b < 2; b++) begin
      @(posedge clk);
      rom_kick <= 1'b1;
      rom_bad <= b[0];
      @(posedge clk);
      rom_kick <= 1'b0;
      repeat (3) @(posedge clk);
      chk("rom_fault", {23'h0, rom_fault}, {23'h0, b[0]});
    end
    clr(3'h4);
    chk("rom_fault", {23'h0, rom_fault}, 24'h000000);
  endtask
  task automatic t_seq();
    wr(8'h09, 24'h000000, 1'b0);
    wr(8'h0C, 24'hD00000, 1'b0);
    wr(8'h18, 24'hD00000, 1'b0);
    @(posedge clk);
    chk("conv_slot", {20'h0, conv_slot}, 24'h000003);
    chk("conv_setup", {21'h0, conv_setup}, 24'h000005);
    pulse_done();
    chk("tag", {20'h0, status_slot_tag}, 24'h000003);
    chk("conv_slot", {20'h0, conv_slot}, 24'h00000F);
    chk("conv_setup", {21'h0, conv_setup}, 24'h000005);
    pulse_done();
    chk("conv_slot", {20'h0, conv_slot}, 24'h000003);
    wr(8'h0C, 24'h000000, 1'b0);
    wr(8'h18, 24'h000000, 1'b0);
    pulse_done();
    chk("conv_run", {23'h0, conv_run}, 24'h000000);
    chk("tag", {20'h0, status_slot_tag}, 24'h00000F);
    wr(8'h09, 24'h800100, 1'b0);
  endtask
  task automatic t_tally();
    wr(8'h07, 24'h400000, 1'b0);
    mclk_run <= 1'b1;
    repeat (1000) @(posedge clk);
    rchk(8'h08, 24'h000000);
    repeat (100) @(posedge clk);
    rchk(8'h08, 24'h000001);
    mclk_run <= 1'b0;
    wr(8'h07, 24'h000000, 1'b0);
    rchk(8'h08, 24'h000000);
    wr(8'h08, 24'h0000FF, 1'b0);
    wr(8'h07, 24'h400000, 1'b0);
    rchk(8'h08, 24'h000001);
  endtask
  task automatic t_map();
    wr(8'h07, 24'h000002, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      oth <= 3'h1 << i;
      @(posedge clk);
      oth <= 3'h0;
      repeat (250) @(posedge clk);
    end
    chk("map_fault", {23'h0, map_integrity_fault}, 24'h000000);
  endtask
  initial begin
    srst = 1'b1;
    mclk_pin = 1'b0;
    mclk_run = 1'b0;
    mcnt = 3'h0;
    conv_done = 1'b0;
    rom_kick = 1'b0;
    rom_seen = 1'b0;
    rom_bad = 1'b1;
    oth = 3'h0;
    fault_clr = 3'h0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (30) @(posedge clk);
    t_reset();
    t_sum();
    t_rom();
    t_seq();
    t_tally();
    t_map();
    report_and_stop();
  end
endmodule // tb_channel_sequencer_and_integrity_checks
`default_nettype wire
